/* File: logic/sgc_regs.svh */
/*
  Constants of the sector guard block: opcodes, map layout, reset values
  and timing figures. Assumes a 100 MHz core clock.
*/
`ifndef SGC_REGS_SVH
`define SGC_REGS_SVH

`define SGC_OP_P0 8'h3d
`define SGC_OP_P1 8'h2a
`define SGC_OP_P2 8'h7f
`define SGC_OP_ENABLE 8'ha9
`define SGC_OP_DISABLE 8'h9a
`define SGC_OP_MAP_ERASE 8'hcf
`define SGC_OP_MAP_PROG 8'hfc

`define SGC_IDX_CMD 6'd3
`define SGC_IDX_DATA 6'd4
`define SGC_BYTE_CNT_MAX 6'h3f

`define SGC_MAP_BYTES 32
`define SGC_MAP_FACTORY 8'h00
`define SGC_MAP_ERASED 8'hff
`define SGC_SEC0_SPLIT_PAGE 8'h08
`define SGC_SEC0_LOW_MSB 7
`define SGC_SEC0_HIGH_MSB 5
`define SGC_PAIR_SET 2'h3

`define SGC_CLK_NS 10
`define SGC_GUARD_ASSERT_NS 1000
`define SGC_GUARD_RELEASE_NS 1000
`define SGC_MAP_ERASE_US 30
`define SGC_MAP_PROG_US 30
`define SGC_GUARD_FILT_CYC (`SGC_GUARD_ASSERT_NS / `SGC_CLK_NS - 3)
`define SGC_MAP_ERASE_CYC (`SGC_MAP_ERASE_US * 1000 / `SGC_CLK_NS)
`define SGC_MAP_PROG_CYC (`SGC_MAP_PROG_US * 1000 / `SGC_CLK_NS)

`endif

/* File: logic/sgc_pkg.sv */
/*
  Types of the sector guard block: states, decoded commands, carriers.
  Assumes nothing of its surroundings.
*/
`default_nettype none
package sgc_pkg;
  typedef enum logic [1:0] {
    SGC_IDLE = 2'b00,
    SGC_ERASE = 2'b01,
    SGC_PROG = 2'b10
  } sgc_state_t;

  typedef enum logic [2:0] {
    SGC_CMD_NONE = 3'b000,
    SGC_CMD_ENABLE = 3'b001,
    SGC_CMD_DISABLE = 3'b010,
    SGC_CMD_ERASE = 3'b011,
    SGC_CMD_PROG = 3'b100
  } sgc_cmd_t;

  typedef struct packed {
    logic valid;
    logic [4:0] sector;
    logic [7:0] page;
  } sgc_arr_req_t;

  typedef struct packed {
    logic busy;
    logic protect_on;
    logic sw_enable;
    logic guard_active;
  } sgc_status_t;
endpackage : sgc_pkg
`default_nettype wire

/* File: logic/sgc_guard_filter.sv */
/*
  Noise filter for the active-low guard pin.
  Assumes the pin is asynchronous to clock and idles high.
*/
`timescale 1ns/1ps
`default_nettype none
module sgc_guard_filter #(
  parameter int FILTER_CYCLES = 8
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic guard_n,
  output logic guard_active
);
  localparam int CW = $clog2(FILTER_CYCLES + 1);
  logic meta_n;
  logic sync_n;
  logic [CW-1:0] cnt;

  generate
    if (FILTER_CYCLES < 2) begin : g_bad_filter
      $error("FILTER_CYCLES below 2");
    end
  endgenerate

  // Two-stage synchroniser
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      meta_n <= 1'b1;
      sync_n <= 1'b1;
    end else begin
      meta_n <= guard_n;
      sync_n <= meta_n;
    end
  end

  // Level must stand FILTER_CYCLES before it is taken
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= '0;
      guard_active <= 1'b0;
    end else if (sync_n == guard_active) begin
      if (cnt == CW'(FILTER_CYCLES - 1)) begin
        guard_active <= ~guard_active;
        cnt <= '0;
      end else begin
        cnt <= cnt + CW'(1);
      end
    end else begin
      cnt <= '0;
    end
  end

  chk_filter_hold: assert property (@(posedge clock) disable iff (!rst_n)
    $changed(guard_active) |-> $past(cnt) == CW'(FILTER_CYCLES - 1))
    else $error("guard level taken before filter time");
endmodule : sgc_guard_filter
`default_nettype wire

/* File: logic/sgc_sector_guard_control.sv */
/*
  Sector guard control: protection state, 32-byte map, map erase/program.
  Assumes link_clk runs only inside cs_n frames and the guard pin is async.
*/
`timescale 1ns/1ps
`default_nettype none
`include "sgc_regs.svh"
// Summary of operation
// - Guard pin asserted blocks protected sector writes
// - Guard assertion turns protection on
// - Guard release without enable turns protection off
// - Earlier enable survives guard release
// - Disable ignored while guard asserted
// - Guard input filtered against short pulses
// - Map byte n guards sector n
// - All ones protects, all zeros unprotects
// - Sector zero split by two bit pairs
// - Map erase opcode, starts at frame end
// - Map erase self-timed, busy throughout
// - Map erase allowed whenever not busy, leaves all protected
// - Map program opcode plus 32 bytes
// - Map program self-timed, busy throughout
// - Extra program bytes wrap to location zero
// - Map program allowed with protection on
// - Program uses working buffer, overwriting it
// - Map starts all zeros
// - Enable opcode, applies at frame end
// - Disable opcode, applies at frame end
// - Software enable cleared at reset
module sgc_sector_guard_control #(
  parameter int ERASE_CYCLES = `SGC_MAP_ERASE_CYC,
  parameter int PROG_CYCLES = `SGC_MAP_PROG_CYC,
  parameter int FILTER_CYCLES = `SGC_GUARD_FILT_CYC
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic link_clk,
  input wire logic cs_n,
  input wire logic wide_mode,
  input wire logic serial_in,
  input wire logic [7:0] parallel_command_lines,
  input wire logic guard_n,
  input wire sgc_pkg::sgc_arr_req_t arr_req,
  output logic arr_grant,
  output logic arr_reject,
  output sgc_pkg::sgc_status_t status,
  output logic [255:0] sector_guard_map
);
  import sgc_pkg::*;

  localparam int MAXC = (ERASE_CYCLES > PROG_CYCLES) ? ERASE_CYCLES : PROG_CYCLES;
  localparam int TW = $clog2(MAXC + 1);

  generate
    if (ERASE_CYCLES < 8 || PROG_CYCLES < 8) begin : g_bad_time
      $error("map times below 8 cycles");
    end
  endgenerate

  function automatic logic [7:0] prefix_byte(input logic [5:0] idx);
    case (idx)
      6'd0: prefix_byte = `SGC_OP_P0;
      6'd1: prefix_byte = `SGC_OP_P1;
      default: prefix_byte = `SGC_OP_P2;
    endcase
  endfunction : prefix_byte

  function automatic sgc_cmd_t decode_cmd(input logic hdr, input logic [7:0] b);
    sgc_cmd_t c;
    c = SGC_CMD_NONE;
    if (hdr) begin
      case (b)
        `SGC_OP_ENABLE: c = SGC_CMD_ENABLE;
        `SGC_OP_DISABLE: c = SGC_CMD_DISABLE;
        `SGC_OP_MAP_ERASE: c = SGC_CMD_ERASE;
        `SGC_OP_MAP_PROG: c = SGC_CMD_PROG;
        default: c = SGC_CMD_NONE;
      endcase
    end
    return c;
  endfunction : decode_cmd

  function automatic logic sector_locked(input logic [7:0] b, input logic [4:0] s,
      input logic [7:0] pg);
    if (s != 5'h00) begin
      sector_locked = (b == `SGC_MAP_ERASED);
    end else if (pg < `SGC_SEC0_SPLIT_PAGE) begin
      sector_locked = (b[`SGC_SEC0_LOW_MSB -: 2] == `SGC_PAIR_SET);
    end else begin
      sector_locked = (b[`SGC_SEC0_HIGH_MSB -: 2] == `SGC_PAIR_SET);
    end
  endfunction : sector_locked

  // Link side: byte assembly
  logic [2:0] bit_cnt;
  logic [6:0] shreg;
  logic [5:0] byte_cnt;
  logic [4:0] data_idx;
  logic hdr_ok;
  logic [7:0] in_byte;
  logic byte_done;
  sgc_cmd_t link_cmd;
  logic link_tog;
  logic [7:0] link_buf [0:`SGC_MAP_BYTES-1];

  always_comb begin
    if (wide_mode) begin
      in_byte = parallel_command_lines;
      byte_done = 1'b1;
    end else begin
      in_byte = {shreg, serial_in};
      byte_done = (bit_cnt == 3'h7);
    end
  end

  // Frame counters, cleared while chip select is high
  always_ff @(posedge link_clk or posedge cs_n) begin
    if (cs_n) begin
      bit_cnt <= 3'h0;
      shreg <= 7'h00;
      byte_cnt <= 6'h00;
      data_idx <= 5'h00;
      hdr_ok <= 1'b1;
    end else begin
      bit_cnt <= bit_cnt + 3'h1;
      shreg <= in_byte[6:0];
      if (byte_done) begin
        if (byte_cnt != `SGC_BYTE_CNT_MAX) begin
          byte_cnt <= byte_cnt + 6'h01;
        end
        if (byte_cnt < `SGC_IDX_CMD && in_byte != prefix_byte(byte_cnt)) begin
          hdr_ok <= 1'b0;
        end
        if (byte_cnt >= `SGC_IDX_DATA) begin
          data_idx <= data_idx + 5'h01;
        end
      end
    end
  end

  // Opcode decode at fourth byte, announced by toggle
  always_ff @(posedge link_clk or negedge rst_n) begin
    if (!rst_n) begin
      link_cmd <= SGC_CMD_NONE;
      link_tog <= 1'b0;
    end else if (byte_done && byte_cnt == `SGC_IDX_CMD) begin
      link_cmd <= decode_cmd(hdr_ok, in_byte);
      link_tog <= ~link_tog;
    end
  end

  // Working buffer takes map data bytes
  always_ff @(posedge link_clk) begin
    if (!cs_n && byte_done && byte_cnt >= `SGC_IDX_DATA && link_cmd == SGC_CMD_PROG) begin
      link_buf[data_idx] <= in_byte;
    end
  end

  // Core side: crossings
  logic cs_meta;
  logic cs_sync;
  logic tog_meta;
  logic tog_sync;
  logic tog_seen;
  sgc_cmd_t pend_cmd;
  logic exec_now;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cs_meta <= 1'b1;
      cs_sync <= 1'b1;
      tog_meta <= 1'b0;
      tog_sync <= 1'b0;
    end else begin
      cs_meta <= cs_n;
      cs_sync <= cs_meta;
      tog_meta <= link_tog;
      tog_sync <= tog_meta;
    end
  end

  // Command waits for end of frame
  assign exec_now = cs_sync && (pend_cmd != SGC_CMD_NONE);

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      tog_seen <= 1'b0;
      pend_cmd <= SGC_CMD_NONE;
    end else if (tog_sync != tog_seen) begin
      tog_seen <= tog_sync;
      pend_cmd <= link_cmd;
    end else if (exec_now) begin
      pend_cmd <= SGC_CMD_NONE;
    end
  end

  // Protection state
  logic guard_active;
  logic sw_enable;
  logic protect_on;

  sgc_guard_filter #(
    .FILTER_CYCLES(FILTER_CYCLES)
  ) u_guard_filter (
    .clock(clock),
    .rst_n(rst_n),
    .guard_n(guard_n),
    .guard_active(guard_active)
  );

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      sw_enable <= 1'b0;
    end else if (exec_now && pend_cmd == SGC_CMD_ENABLE) begin
      sw_enable <= 1'b1;
    end else if (exec_now && pend_cmd == SGC_CMD_DISABLE && !guard_active) begin
      sw_enable <= 1'b0;
    end
  end

  assign protect_on = sw_enable | guard_active;

  // Map erase and program sequencer
  sgc_state_t state;
  logic [TW-1:0] timer;
  logic [7:0] gmap [0:`SGC_MAP_BYTES-1];
  logic busy;

  assign busy = (state != SGC_IDLE);

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state <= SGC_IDLE;
      timer <= '0;
    end else begin
      unique case (state)
        SGC_IDLE: begin
          if (exec_now && pend_cmd == SGC_CMD_ERASE) begin
            state <= SGC_ERASE;
            timer <= TW'(ERASE_CYCLES - 1);
          end else if (exec_now && pend_cmd == SGC_CMD_PROG) begin
            state <= SGC_PROG;
            timer <= TW'(PROG_CYCLES - 1);
          end
        end
        SGC_ERASE, SGC_PROG: begin
          if (timer == '0) begin
            state <= SGC_IDLE;
          end else begin
            timer <= timer - TW'(1);
          end
        end
        default: begin
          state <= SGC_IDLE;
        end
      endcase
    end
  end

  // Map contents, one byte per sector
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < `SGC_MAP_BYTES; i++) begin
        gmap[i] <= `SGC_MAP_FACTORY;
      end
    end else if (timer == '0 && state == SGC_ERASE) begin
      for (int i = 0; i < `SGC_MAP_BYTES; i++) begin
        gmap[i] <= `SGC_MAP_ERASED;
      end
    end else if (timer == '0 && state == SGC_PROG) begin
      for (int i = 0; i < `SGC_MAP_BYTES; i++) begin
        gmap[i] <= link_buf[i];
      end
    end
  end

  generate
    for (genvar g = 0; g < `SGC_MAP_BYTES; g++) begin : g_map_out
      assign sector_guard_map[g*8 +: 8] = gmap[g];
    end
  endgenerate

  // Array write gate
  logic sel_locked;
  assign sel_locked = sector_locked(gmap[arr_req.sector], arr_req.sector, arr_req.page);

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      arr_grant <= 1'b0;
      arr_reject <= 1'b0;
    end else begin
      arr_grant <= 1'b0;
      arr_reject <= 1'b0;
      if (arr_req.valid) begin
        if (busy || (protect_on && sel_locked)) begin
          arr_reject <= 1'b1;
        end else begin
          arr_grant <= 1'b1;
        end
      end
    end
  end

  assign status = '{busy: busy, protect_on: protect_on, sw_enable: sw_enable,
                    guard_active: guard_active};

  // Checks
  sequence map_erase_begins;
    state == SGC_IDLE && exec_now && pend_cmd == SGC_CMD_ERASE;
  endsequence

  sequence map_prog_begins;
    state == SGC_IDLE && exec_now && pend_cmd == SGC_CMD_PROG;
  endsequence

  chk_guard_rejects: assert property (@(posedge clock) disable iff (!rst_n)
    arr_req.valid && guard_active && sel_locked |=> arr_reject && !arr_grant)
    else $error("protected sector write not refused under guard");

  chk_guard_forces: assert property (@(posedge clock) disable iff (!rst_n)
    $rose(guard_active) |-> status.protect_on)
    else $error("guard did not turn protection on");

  chk_release_off: assert property (@(posedge clock) disable iff (!rst_n)
    $fell(guard_active) && !sw_enable |-> !status.protect_on)
    else $error("protection stayed on after guard release");

  chk_enable_holds: assert property (@(posedge clock) disable iff (!rst_n)
    $fell(guard_active) && sw_enable |-> status.protect_on [*2])
    else $error("guard release dropped software protection");

  chk_disable_ignored: assert property (@(posedge clock) disable iff (!rst_n)
    exec_now && pend_cmd == SGC_CMD_DISABLE && guard_active && sw_enable |=> sw_enable)
    else $error("disable taken while guard asserted");

  chk_enable_sets: assert property (@(posedge clock) disable iff (!rst_n)
    exec_now && pend_cmd == SGC_CMD_ENABLE |=> sw_enable && status.protect_on)
    else $error("enable command not applied");

  chk_erase_busy: assert property (@(posedge clock) disable iff (!rst_n)
    map_erase_begins |=> status.busy [*8])
    else $error("map erase not busy");

  chk_erase_timer: assert property (@(posedge clock) disable iff (!rst_n)
    map_erase_begins |=> state == SGC_ERASE && timer == TW'(ERASE_CYCLES - 1))
    else $error("map erase time wrong");

  chk_erase_result: assert property (@(posedge clock) disable iff (!rst_n)
    state == SGC_ERASE && timer == '0 |=> !busy && gmap[0] == `SGC_MAP_ERASED
      && gmap[`SGC_MAP_BYTES-1] == `SGC_MAP_ERASED)
    else $error("map erase did not leave all protected");

  chk_prog_busy: assert property (@(posedge clock) disable iff (!rst_n)
    map_prog_begins |=> status.busy [*8] ##0 state == SGC_PROG)
    else $error("map program not busy");

  chk_prog_store: assert property (@(posedge clock) disable iff (!rst_n)
    state == SGC_PROG && timer == '0 |=> gmap[0] == $past(link_buf[0]) && !busy)
    else $error("map program did not store buffer");

  chk_reject_quiet: assert property (@(posedge clock) disable iff (!rst_n)
    arr_reject && !$past(busy) && !$past(exec_now) |-> !busy && !arr_grant)
    else $error("rejected write reported busy");

  chk_data_wrap: assert property (@(posedge link_clk) disable iff (cs_n)
    byte_done && byte_cnt >= `SGC_IDX_DATA && data_idx == 5'h1f |=> data_idx == 5'h00)
    else $error("map data did not wrap");
endmodule : sgc_sector_guard_control
`default_nettype wire

/* File: tb/sgc_host_model.sv */
/*
  Host side of the command link: frames opcodes and data onto the link.
  Assumes the link clock runs only inside a chip-select frame.
*/
`timescale 1ns/1ps
`default_nettype none
module sgc_host_model (
  output logic link_clk,
  output logic cs_n,
  output logic wide_mode,
  output logic serial_in,
  output logic [7:0] parallel_command_lines
);
  initial begin
    link_clk = 1'b0;
    cs_n = 1'b1;
    wide_mode = 1'b0;
    serial_in = 1'b1;
    parallel_command_lines = 8'h00;
  end

  // One whole frame, 12 ns link clock, data set while the clock is low
  task automatic send_frame(input logic wide, input logic [7:0] bytes [0:36], input int n);
    wide_mode = wide;
    #3 cs_n = 1'b0;
    for (int i = 0; i < n; i++) begin
      if (wide) begin
        parallel_command_lines = bytes[i];
        #6 link_clk = 1'b1;
        #6 link_clk = 1'b0;
      end else begin
        for (int b = 7; b >= 0; b--) begin
          serial_in = bytes[i][b];
          #6 link_clk = 1'b1;
          #6 link_clk = 1'b0;
        end
      end
    end
    #6 cs_n = 1'b1;
    // Released lines no longer show the last value
    serial_in = ~serial_in;
    parallel_command_lines = ~parallel_command_lines;
    #60;
  endtask : send_frame
endmodule : sgc_host_model
`default_nettype wire

/* File: tb/sector_guard_control_bench.sv */
/*
  Self-checking bench of the sector guard block with a host link model.
  Assumes short map times and a short guard filter set by parameters.
*/
`timescale 1ns/1ps
`default_nettype none
module sector_guard_control_bench;
  import sgc_pkg::*;
  localparam int ERASE_N = 8;
  localparam int PROG_N = 8;
  localparam int FILT_N = 4;
  logic clock, rst_n, guard_n, link_clk, cs_n, wide_mode, serial_in, arr_grant, arr_reject;
  logic [7:0] parallel_command_lines;
  sgc_arr_req_t arr_req;
  sgc_status_t status;
  logic [255:0] sector_guard_map, exp_map;
  logic [7:0] pd [0:32];
  logic [7:0] fr [0:36];
  logic [31:0] seed, r;
  int mismatches, cmp_count, busy_run, busy_len;

  sgc_sector_guard_control #(.ERASE_CYCLES(ERASE_N), .PROG_CYCLES(PROG_N),
    .FILTER_CYCLES(FILT_N)) uut (.clock(clock), .rst_n(rst_n), .link_clk(link_clk),
    .cs_n(cs_n), .wide_mode(wide_mode), .serial_in(serial_in),
    .parallel_command_lines(parallel_command_lines), .guard_n(guard_n), .arr_req(arr_req),
    .arr_grant(arr_grant), .arr_reject(arr_reject), .status(status),
    .sector_guard_map(sector_guard_map));

  sgc_host_model host (.link_clk(link_clk), .cs_n(cs_n), .wide_mode(wide_mode),
    .serial_in(serial_in), .parallel_command_lines(parallel_command_lines));

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  // Length of the last busy run
  always @(posedge clock) begin
    if (status.busy === 1'b1) begin
      busy_run <= busy_run + 1;
    end else if (busy_run != 0) begin
      busy_len <= busy_run;
      busy_run <= 0;
    end
  end

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs

  function automatic logic locked(logic [255:0] m, logic [4:0] s, logic [7:0] p);
    logic [7:0] b;
    b = m[s*8 +: 8];
    if (s == 5'd0) return (p < 8'h08) ? (b[7:6] == 2'h3) : (b[5:4] == 2'h3);
    return b == 8'hff;
  endfunction : locked

  task automatic check(input string name, input logic [255:0] seen, input logic [255:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected %s: expected %h, seen %h", name, exp, seen);
    end
  endtask : check

  task automatic wrap_up;
    if (mismatches == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : wrap_up

  task automatic cmd(input logic wide, input logic [7:0] op, input int nd);
    fr[0] = 8'h3d;
    fr[1] = 8'h2a;
    fr[2] = 8'h7f;
    fr[3] = op;
    for (int i = 0; i < nd; i++) fr[4+i] = pd[i];
    @(negedge clock);
    host.send_frame(wide, fr, 4 + nd);
    @(negedge clock);
  endtask : cmd

  task automatic req(input logic [4:0] s, input logic [7:0] p, input logic grant);
    @(negedge clock) arr_req = '{valid: 1'b1, sector: s, page: p};
    @(negedge clock) arr_req.valid = 1'b0;
    check("arr_grant", arr_grant, grant);
    check("arr_reject", arr_reject, !grant);
  endtask : req

  task automatic wait_idle;
    for (int i = 0; i < 100 && status.busy !== 1'b0; i++) @(negedge clock);
    check("busy", status.busy, 1'b0);
    @(negedge clock);
  endtask : wait_idle

  task automatic guard(input logic lvl);
    @(negedge clock) guard_n = lvl;
    repeat (FILT_N + 6) @(negedge clock);
  endtask : guard

  initial begin
    #100000;
    mismatches++;
    wrap_up();
  end

  initial begin
    rst_n = 1'b0;
    guard_n = 1'b1;
    arr_req = '0;
    seed = 32'h9c7f;
    mismatches = 0;
    cmp_count = 0;
    busy_run = 0;
    busy_len = 0;
    repeat (3) @(negedge clock);
    rst_n = 1'b1;
    repeat (FILT_N + 4) @(negedge clock);
    check("map", sector_guard_map, '0);
    check("status", status, '0);
    req(5'd3, 8'h00, 1'b1);
    cmd(1'b0, 8'ha9, 0);
    check("sw_enable", status.sw_enable, 1'b1);
    req(5'd7, 8'h20, 1'b1);
    cmd(1'b0, 8'hcf, 0);
    req(5'd2, 8'h00, 1'b0);
    wait_idle();
    check("erase busy", busy_len, ERASE_N);
    check("map", sector_guard_map, {256{1'b1}});
    req(5'd9, 8'h10, 1'b0);
    check("busy", status.busy, 1'b0);
    check("map", sector_guard_map, {256{1'b1}});
    // Random all-ones or all-zeros bytes; sector zero by bit pairs
    for (int i = 0; i < 33; i++) begin
      r = xs();
      pd[i] = r[0] ? 8'hff : 8'h00;
      if (i % 32 == 0) pd[i] = {{2{r[3]}}, {2{r[4]}}, r[11:8]};
    end
    pd[1] = 8'hff;
    pd[2] = 8'h00;
    for (int i = 0; i < 33; i++) exp_map[8*(i%32) +: 8] = pd[i];
    cmd(1'b1, 8'hfc, 33);
    wait_idle();
    check("prog busy", busy_len, PROG_N);
    check("map", sector_guard_map, exp_map);
    req(5'd0, 8'h07, !locked(exp_map, 5'd0, 8'h07));
    req(5'd0, 8'h08, !locked(exp_map, 5'd0, 8'h08));
    req(5'd2, 8'h00, 1'b1);
    for (int i = 0; i < 24; i++) begin
      r = xs();
      req(r[4:0], r[15:8], !locked(exp_map, r[4:0], r[15:8]));
    end
    // Disable with a broken prefix is ignored
    fr[1] = 8'h2b;
    fr[3] = 8'h9a;
    @(negedge clock);
    host.send_frame(1'b1, fr, 4);
    @(negedge clock);
    check("sw_enable", status.sw_enable, 1'b1);
    cmd(1'b1, 8'h9a, 0);
    check("sw_enable", status.sw_enable, 1'b0);
    req(5'd1, 8'h00, 1'b1);
    @(negedge clock) guard_n = 1'b0;
    repeat (2) @(negedge clock);
    guard(1'b1);
    check("guard_active", status.guard_active, 1'b0);
    guard(1'b0);
    check("protect_on", status.protect_on, 1'b1);
    req(5'd1, 8'h00, 1'b0);
    cmd(1'b0, 8'ha9, 0);
    cmd(1'b0, 8'h9a, 0);
    check("sw_enable", status.sw_enable, 1'b1);
    guard(1'b1);
    check("protect_on", status.protect_on, 1'b1);
    cmd(1'b0, 8'h9a, 0);
    check("protect_on", status.protect_on, 1'b0);
    guard(1'b0);
    guard(1'b1);
    check("protect_on", status.protect_on, 1'b0);
    // Mid-run reset clears the software enable
    cmd(1'b1, 8'ha9, 0);
    check("sw_enable", status.sw_enable, 1'b1);
    rst_n = 1'b0;
    repeat (3) @(negedge clock);
    rst_n = 1'b1;
    @(negedge clock);
    check("sw_enable", status.sw_enable, 1'b0);
    check("map", sector_guard_map, '0);
    wrap_up();
  end
endmodule : sector_guard_control_bench
`default_nettype wire
